/* logic/fault_resp_params.svh */
/*
  Shared offsets, field positions, reset values and timing counts of the output
  fault response registers. Assumes inclusion by bare name from the logic files.
*/
`ifndef FAULT_RESP_PARAMS_SVH
`define FAULT_RESP_PARAMS_SVH

// ---------------------------------------------------------------
// command codes and register slots
// ---------------------------------------------------------------
`define CMD_UV_ACTION     8'h45
`define CMD_OC_PEAK       8'h46
`define CMD_UC_VALLEY     8'h4b
`define SLOT_UV_ACTION    2'h0
`define SLOT_OC_PEAK      2'h1
`define SLOT_UC_VALLEY    2'h2
`define NUM_SLOTS         3

// ---------------------------------------------------------------
// reset values and fields
// ---------------------------------------------------------------
`define UV_ACTION_RESET   16'h0080
`define OC_PEAK_RESET     16'hda80
`define UC_VALLEY_RESET   16'hdd80
`define ACT_MSB           7
`define ACT_LSB           6
`define ACT_DISABLE_RETRY 2'h2
`define RETRY_MSB         5
`define RETRY_LSB         3
`define RETRY_NONE        3'h0
`define RETRY_ALWAYS      3'h7
`define LIN_EXP_MSB       15
`define LIN_EXP_LSB       11
`define LIN_MANT_MSB      10

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define CLK_HZ            10000000
`define UV_RETRY_MS       70
`define UV_RETRY_CYCLES   ((`UV_RETRY_MS * `CLK_HZ) / 1000)

`endif

/* logic/fault_resp_pkg.sv */
/*
  Types of the output fault response block.
  Assumes the params header is compiled alongside.
*/
package fault_resp_pkg;
  typedef logic [15:0] word_t;
  typedef enum logic [1:0] {UV_RUN, UV_HOLD, UV_WAIT} uv_state_t;
endpackage : fault_resp_pkg

/* logic/paged_reg_store.sv */
/*
  Paged storage of the three fault response registers for both outputs,
  with a registered read port and a flat view of every word.
  Assumes index = page * 3 + slot, supplied by the owner.
*/
`timescale 1ns/1ns
`include "fault_resp_params.svh"

module paged_reg_store
  import fault_resp_pkg::*;
(
  input  wire logic             i_clk,
  input  wire logic             i_reset_n,
  input  wire logic             i_wr,
  input  wire logic [2:0]       i_wr_index,
  input  wire word_t            i_wr_data,
  input  wire logic             i_rd,
  input  wire logic [2:0]       i_rd_index,
  output word_t                 o_rd_data,
  output word_t [5:0]           o_words
);

  word_t [5:0] words;
  word_t [5:0] next_words;
  word_t       rd_data;
  word_t       next_rd_data;

  // write port and registered read port
  always_comb begin
    next_words = words;
    next_rd_data = rd_data;
    if (i_wr) begin
      next_words[i_wr_index] = i_wr_data;
    end
    if (i_rd) begin
      next_rd_data = words[i_rd_index];
    end
  end

  // defaults are constants so the async reset loads nothing else
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      words <= {`UC_VALLEY_RESET, `OC_PEAK_RESET, `UV_ACTION_RESET,
                `UC_VALLEY_RESET, `OC_PEAK_RESET, `UV_ACTION_RESET};
      rd_data <= '0;
    end else begin
      words <= next_words;
      rd_data <= next_rd_data;
    end
  end

  assign o_rd_data = rd_data;
  assign o_words = words;

  property p_read_page;
    @(posedge i_clk) disable iff (!i_reset_n)
      (i_rd && !i_wr) |=> (rd_data == $past(words[i_rd_index]));
  endproperty
  a_read_page: assert property (p_read_page) else $error("read data not from selected word");

endmodule : paged_reg_store

/* logic/output_fault_response_regs.sv */
/*
  Output fault response registers for two output pages: undervoltage response
  with disable and timed retry, peak overcurrent and valley undercurrent
  thresholds checked against blanked, consecutive current samples, sticky
  fault flags and the active-low alert line.
  Assumes a bus front end that decodes commands into one-cycle strobes on this
  clock, a core that supplies current samples in linear-11 form, and an
  enable pin that is asynchronous to i_clk.
*/
`timescale 1ns/1ns
`include "fault_resp_params.svh"

// Summary of operation
// - undervoltage is declared only once output good has been seen.
// - undervoltage response register resets to shut down, no retries.
// - retry spacing after undervoltage is seventy milliseconds.
// - action code 10 disables the output, then follows the retry code.
// - every undervoltage response pulls the alert line low and sets a flag.
// - fault flags clear only on the clear-faults command.
// - retry code 000 holds the output off until faults are cleared.
// - retry code 111 restarts endlessly until commanded off or shut down.
// - thresholds compare only samples taken after blanking ends.
// - overcurrent needs the configured number of consecutive samples.
// - undercurrent needs the configured number of consecutive samples.
// - peak overcurrent shares flag and response with the averaged limit.
// - valley undercurrent shares flag and response with the averaged limit.
// - thresholds are linear-11: exponent 15:11, mantissa 10:0, amperes.
// - peak overcurrent threshold resets to twenty amperes.
// - valley undercurrent threshold resets to minus twenty amperes.
// - every setting but the consecutive count is held per page; the page picks the target.
module output_fault_response_regs
  import fault_resp_pkg::*;
#(
  parameter int unsigned RETRY_CYCLES = `UV_RETRY_CYCLES
)(
  input  wire logic             i_clk,
  input  wire logic             i_reset_n,
  input  wire logic             i_cmd_wr,
  input  wire logic             i_cmd_rd,
  input  wire logic [7:0]       i_cmd_code,
  input  wire logic             i_page,
  input  wire word_t            i_wr_data,
  input  wire logic             i_clear_faults,
  input  wire logic [1:0]       i_output_good,
  input  wire logic [1:0]       i_vout_below_uv,
  input  wire logic [1:0]       i_enable_pin,
  input  wire logic [1:0]       i_operation_on,
  input  wire logic             i_bias_good,
  input  wire logic [1:0]       i_other_shutdown,
  input  wire logic [1:0]       i_sample_valid,
  input  wire word_t [1:0]      i_current_sample,
  input  wire logic [1:0]       i_blank_done,
  input  wire logic [3:0]       i_consec_count,
  input  wire logic [1:0]       i_avg_oc_fault,
  input  wire logic [1:0]       i_avg_uc_fault,
  output word_t                 o_rd_data,
  output logic                  o_rd_valid,
  output logic [1:0]            o_output_disable,
  output logic [1:0]            o_uv_fault_flag,
  output logic [1:0]            o_oc_fault_flag,
  output logic [1:0]            o_uc_fault_flag,
  output logic [1:0]            o_oc_event,
  output logic [1:0]            o_uc_event,
  output logic                  o_alert_line_n
);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // linear-11 to a common fixed point, 2^16 per ampere unit step of 2^-16
  function automatic logic signed [47:0] lin11_to_fix(input word_t w);
    logic signed [47:0] mant;
    logic [5:0]         shift;
    mant = 48'(signed'(w[`LIN_MANT_MSB:0]));
    shift = 6'({w[`LIN_EXP_MSB], w[`LIN_EXP_MSB:`LIN_EXP_LSB]}) + 6'd16;
    return mant <<< shift;
  endfunction : lin11_to_fix

  function automatic logic [1:0] cmd_slot(input logic [7:0] code, output logic hit);
    hit = 1'b1;
    case (code)
      `CMD_UV_ACTION: cmd_slot = `SLOT_UV_ACTION;
      `CMD_OC_PEAK:   cmd_slot = `SLOT_OC_PEAK;
      `CMD_UC_VALLEY: cmd_slot = `SLOT_UC_VALLEY;
      default: begin
        hit = 1'b0;
        cmd_slot = `SLOT_UV_ACTION;
      end
    endcase
  endfunction : cmd_slot

  function automatic logic [2:0] slot_index(input logic page, input logic [1:0] slot);
    return page ? 3'(slot) + 3'd3 : 3'(slot);
  endfunction : slot_index

  // ---------------------------------------------------------------
  // register access
  // ---------------------------------------------------------------
  logic        cmd_hit;
  logic [1:0]  slot;
  logic        store_wr;
  logic        store_rd;
  word_t       store_wdata;
  word_t [5:0] words;
  logic        rd_valid;
  logic        next_rd_valid;

  // unmapped codes are neither stored nor answered
  always_comb begin
    slot = cmd_slot(i_cmd_code, cmd_hit);
    store_wr = i_cmd_wr & cmd_hit;
    store_rd = i_cmd_rd & cmd_hit;
    next_rd_valid = store_rd;
    // the one-byte register keeps only its low byte; odd codes kept as is
    store_wdata = (slot == `SLOT_UV_ACTION) ? {8'h00, i_wr_data[7:0]} : i_wr_data;
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= next_rd_valid;
    end
  end

  paged_reg_store u_store (
    .i_clk      (i_clk),
    .i_reset_n  (i_reset_n),
    .i_wr       (store_wr),
    .i_wr_index (slot_index(i_page, slot)),
    .i_wr_data  (store_wdata),
    .i_rd       (store_rd),
    .i_rd_index (slot_index(i_page, slot)),
    .o_rd_data  (o_rd_data),
    .o_words    (words)
  );

  // ---------------------------------------------------------------
  // enable pin synchroniser
  // ---------------------------------------------------------------
  logic [1:0] en_meta;
  logic [1:0] en_sync;

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      en_meta <= 2'h0;
      en_sync <= 2'h0;
    end else begin
      en_meta <= i_enable_pin;
      en_sync <= en_meta;
    end
  end

  // ---------------------------------------------------------------
  // fault detection and undervoltage response
  // ---------------------------------------------------------------
  uv_state_t [1:0]   uv_state;
  uv_state_t [1:0]   next_uv_state;
  logic [1:0][31:0]  retry_cnt;
  logic [1:0][31:0]  next_retry_cnt;
  logic [1:0][3:0]   oc_cnt;
  logic [1:0][3:0]   next_oc_cnt;
  logic [1:0][3:0]   uc_cnt;
  logic [1:0][3:0]   next_uc_cnt;
  logic [1:0]        pg_armed;
  logic [1:0]        next_pg_armed;
  logic [1:0]        out_off;
  logic [1:0]        next_out_off;
  logic [1:0]        uv_flag;
  logic [1:0]        next_uv_flag;
  logic [1:0]        oc_flag;
  logic [1:0]        next_oc_flag;
  logic [1:0]        uc_flag;
  logic [1:0]        next_uc_flag;
  logic [1:0]        oc_evt;
  logic [1:0]        next_oc_evt;
  logic [1:0]        uc_evt;
  logic [1:0]        next_uc_evt;
  logic [1:0]        uv_evt;
  logic              alert_n;
  logic              next_alert_n;
  logic [3:0]        need;

  always_comb begin
    need = (i_consec_count == 4'h0) ? 4'h1 : i_consec_count;
    next_uv_state = uv_state;
    next_retry_cnt = retry_cnt;
    next_oc_cnt = oc_cnt;
    next_uc_cnt = uc_cnt;
    next_out_off = out_off;
    next_pg_armed = pg_armed;
    next_oc_evt = 2'h0;
    next_uc_evt = 2'h0;
    uv_evt = 2'h0;
    for (int p = 0; p < 2; p++) begin
      // arming sets on output good, holds when output good falls, and drops whenever the output is off
      uv_evt[p] = pg_armed[p] & i_vout_below_uv[p] & ~out_off[p];
      if (out_off[p]) begin
        next_pg_armed[p] = 1'b0;
      end else if (i_output_good[p]) begin
        next_pg_armed[p] = 1'b1;
      end
      // only post-blanking samples count; a gap in valid keeps the run
      if (i_sample_valid[p] && i_blank_done[p]) begin
        if (lin11_to_fix(i_current_sample[p]) >
            lin11_to_fix(words[slot_index(1'(p), `SLOT_OC_PEAK)])) begin
          next_oc_cnt[p] = (oc_cnt[p] == 4'hf) ? 4'hf : oc_cnt[p] + 4'h1;
        end else begin
          next_oc_cnt[p] = 4'h0;
        end
        if (lin11_to_fix(i_current_sample[p]) <
            lin11_to_fix(words[slot_index(1'(p), `SLOT_UC_VALLEY)])) begin
          next_uc_cnt[p] = (uc_cnt[p] == 4'hf) ? 4'hf : uc_cnt[p] + 4'h1;
        end else begin
          next_uc_cnt[p] = 4'h0;
        end
        next_oc_evt[p] = (next_oc_cnt[p] >= need);
        next_uc_evt[p] = (next_uc_cnt[p] >= need);
      end else if (!i_blank_done[p]) begin
        next_oc_cnt[p] = 4'h0;
        next_uc_cnt[p] = 4'h0;
      end
      // averaged limits feed the same flags and response
      next_oc_evt[p] = next_oc_evt[p] | i_avg_oc_fault[p];
      next_uc_evt[p] = next_uc_evt[p] | i_avg_uc_fault[p];
      case (uv_state[p])
        UV_RUN: begin
          if (uv_evt[p] &&
              words[slot_index(1'(p), `SLOT_UV_ACTION)][`ACT_MSB:`ACT_LSB]
                == `ACT_DISABLE_RETRY) begin
            next_out_off[p] = 1'b1;
            next_retry_cnt[p] = 32'h0;
            // other retry codes fall back to holding off
            if (words[slot_index(1'(p), `SLOT_UV_ACTION)][`RETRY_MSB:`RETRY_LSB]
                == `RETRY_ALWAYS) begin
              next_uv_state[p] = UV_WAIT;
            end else begin
              next_uv_state[p] = UV_HOLD;
            end
          end
        end
        UV_HOLD: begin
          if (i_clear_faults) begin
            next_out_off[p] = 1'b0;
            next_uv_state[p] = UV_RUN;
          end
        end
        UV_WAIT: begin
          if (!en_sync[p] || !i_operation_on[p] || !i_bias_good ||
              i_other_shutdown[p]) begin
            next_uv_state[p] = UV_HOLD;
          end else if (retry_cnt[p] == RETRY_CYCLES - 1) begin
            // restart without looking at the fault again
            next_out_off[p] = 1'b0;
            next_uv_state[p] = UV_RUN;
          end else begin
            next_retry_cnt[p] = retry_cnt[p] + 32'h1;
          end
        end
        default: begin
          next_uv_state[p] = UV_RUN;
        end
      endcase
    end
    // a new event in the clearing cycle keeps its flag
    next_uv_flag = (uv_flag & ~{2{i_clear_faults}}) | uv_evt;
    next_oc_flag = (oc_flag & ~{2{i_clear_faults}}) | next_oc_evt;
    next_uc_flag = (uc_flag & ~{2{i_clear_faults}}) | next_uc_evt;
    next_alert_n = ~(|{next_uv_flag, next_oc_flag, next_uc_flag});
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      uv_state <= '{UV_RUN, UV_RUN};
      retry_cnt <= '0;
      oc_cnt <= '0;
      uc_cnt <= '0;
      pg_armed <= 2'h0;
      out_off <= 2'h0;
      uv_flag <= 2'h0;
      oc_flag <= 2'h0;
      uc_flag <= 2'h0;
      oc_evt <= 2'h0;
      uc_evt <= 2'h0;
      alert_n <= 1'b1;
    end else begin
      uv_state <= next_uv_state;
      retry_cnt <= next_retry_cnt;
      oc_cnt <= next_oc_cnt;
      uc_cnt <= next_uc_cnt;
      pg_armed <= next_pg_armed;
      out_off <= next_out_off;
      uv_flag <= next_uv_flag;
      oc_flag <= next_oc_flag;
      uc_flag <= next_uc_flag;
      oc_evt <= next_oc_evt;
      uc_evt <= next_uc_evt;
      alert_n <= next_alert_n;
    end
  end

  // ---------------------------------------------------------------
  // outputs, all straight from flip-flops
  // ---------------------------------------------------------------
  assign o_rd_valid = rd_valid;
  assign o_output_disable = out_off;
  assign o_uv_fault_flag = uv_flag;
  assign o_oc_fault_flag = oc_flag;
  assign o_uc_fault_flag = uc_flag;
  assign o_oc_event = oc_evt;
  assign o_uc_event = uc_evt;
  assign o_alert_line_n = alert_n;

  // ---------------------------------------------------------------
  // assertions (page 0 stands for both)
  // ---------------------------------------------------------------
  logic first_cyc;

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      first_cyc <= 1'b1;
    end else begin
      first_cyc <= 1'b0;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);

  sequence s_uv_trip;
    uv_evt[0] && uv_state[0] == UV_RUN &&
      words[0][`ACT_MSB:`ACT_LSB] == `ACT_DISABLE_RETRY;
  endsequence
  sequence s_retry_due;
    uv_state[0] == UV_WAIT && retry_cnt[0] == RETRY_CYCLES - 1 && en_sync[0] &&
      i_operation_on[0] && i_bias_good && !i_other_shutdown[0];
  endsequence

  property p_uv_needs_pg;
    $rose(uv_flag[0]) |-> $past(pg_armed[0]);
  endproperty
  a_uv_needs_pg: assert property (p_uv_needs_pg) else $error("uv flag without output good");

  property p_defaults;
    first_cyc |-> words[0] == 16'h0080 && words[1] == 16'hda80 && words[2] == 16'hdd80;
  endproperty
  a_defaults: assert property (p_defaults) else $error("bad register defaults");

  property p_trip_disables;
    s_uv_trip |=> out_off[0] && uv_state[0] != UV_RUN;
  endproperty
  a_trip_disables: assert property (p_trip_disables) else $error("uv trip did not disable");

  property p_alert;
    // a clear with no new event may raise the line again
    (uv_evt[0] || (uv_flag[0] && !i_clear_faults)) |=> !o_alert_line_n;
  endproperty
  a_alert: assert property (p_alert) else $error("alert not low on uv fault");

  property p_sticky;
    (uv_flag[0] || oc_flag[0]) && !i_clear_faults |=>
      ($past(uv_flag[0]) -> uv_flag[0]) && ($past(oc_flag[0]) -> oc_flag[0]);
  endproperty
  a_sticky: assert property (p_sticky) else $error("fault flag lost without clear");

  property p_hold_off;
    uv_state[0] == UV_HOLD && !i_clear_faults |=> out_off[0] && uv_state[0] == UV_HOLD;
  endproperty
  a_hold_off: assert property (p_hold_off) else $error("output left hold early");

  property p_retry_time;
    s_retry_due |=> !out_off[0] && uv_state[0] == UV_RUN;
  endproperty
  a_retry_time: assert property (p_retry_time) else $error("retry not at retry time");

  property p_wait_bound;
    uv_state[0] == UV_WAIT |-> retry_cnt[0] < RETRY_CYCLES && out_off[0];
  endproperty
  a_wait_bound: assert property (p_wait_bound) else $error("retry wait overran");

  property p_oc_count;
    $rose(oc_evt[0]) |-> $past(i_avg_oc_fault[0]) || oc_cnt[0] >= $past(need);
  endproperty
  a_oc_count: assert property (p_oc_count) else $error("oc declared too early");

  property p_blanked;
    !i_blank_done[0] |=> oc_cnt[0] == 4'h0 && uc_cnt[0] == 4'h0;
  endproperty
  a_blanked: assert property (p_blanked) else $error("sample counted during blanking");

endmodule : output_fault_response_regs

/* verif/pmbus_host_model.sv */
/*
  Host side model: issues register commands as one-cycle strobes on the falling edge.
  Assumes the bench calls its tasks and the design answers a read one edge later.
*/
`timescale 1ns/1ns

module pmbus_host_model
  import fault_resp_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_rd_valid,
  input  wire word_t       i_rd_data,
  output logic             o_cmd_wr,
  output logic             o_cmd_rd,
  output logic [7:0]       o_cmd_code,
  output logic             o_page,
  output word_t            o_wr_data,
  output logic             o_clear
);
  // idle lines: strobes low, data parked on a harmless pattern
  initial begin
    o_cmd_wr   = 1'b0;
    o_cmd_rd   = 1'b0;
    o_cmd_code = 8'h00;
    o_page     = 1'b0;
    o_wr_data  = 16'h5a5a;
    o_clear    = 1'b0;
  end

  // one write strobe; data inverted afterwards so a stale word never looks valid
  task automatic wr(input logic p, input logic [7:0] c, input word_t d);
    @(negedge i_clk);
    o_page     = p;
    o_cmd_code = c;
    o_wr_data  = d;
    o_cmd_wr   = 1'b1;
    @(negedge i_clk);
    o_cmd_wr   = 1'b0;
    o_wr_data  = ~d;
  endtask : wr

  // read strobe; the answer stands for one cycle after the taking edge
  task automatic rd(input logic p, input logic [7:0] c, output logic v, output word_t d);
    @(negedge i_clk);
    o_page     = p;
    o_cmd_code = c;
    o_cmd_rd   = 1'b1;
    @(negedge i_clk);
    o_cmd_rd   = 1'b0;
    v          = i_rd_valid;
    d          = i_rd_data;
  endtask : rd

  // clear-faults command as a one-cycle pulse
  task automatic clear();
    @(negedge i_clk);
    o_clear = 1'b1;
    @(negedge i_clk);
    o_clear = 1'b0;
  endtask : clear
endmodule : pmbus_host_model

/* verif/output_fault_response_regs_tb_top.sv */
/*
  Self-checking bench of the output fault response registers with a host model.
  Assumes a shortened retry count and inputs driven on the falling edge.
*/
`timescale 1ns/1ns

module output_fault_response_regs_tb_top;
  import fault_resp_pkg::*;
  localparam int RC = 20;
  logic        clk, rst_n, cwr, crd, pg, clr, bias, rd_valid, alert_n, v, p;
  logic [7:0]  code;
  logic [3:0]  need;
  logic [1:0]  good, below, en, op, oth, sv, blank, aoc, auc;
  logic [1:0]  dis, uvf, ocf, ucf, oce, uce;
  word_t       wdata, rd_data, g, w;
  word_t [1:0] samp;
  word_t       shw [2][3];
  logic [31:0] rng;
  int          mismatches, compares, s;
  word_t       rst_w [3] = '{16'h0080, 16'hda80, 16'hdd80};
  logic [7:0]  codes [3] = '{8'h45, 8'h46, 8'h4b};
  logic [7:0]  acts [5]  = '{8'h80, 8'h00, 8'h40, 8'hc0, 8'h97};

  pmbus_host_model host (.i_clk(clk), .i_rd_valid(rd_valid), .i_rd_data(rd_data),
    .o_cmd_wr(cwr), .o_cmd_rd(crd), .o_cmd_code(code), .o_page(pg),
    .o_wr_data(wdata), .o_clear(clr));

  output_fault_response_regs #(.RETRY_CYCLES(RC)) uut (.i_clk(clk), .i_reset_n(rst_n),
    .i_cmd_wr(cwr), .i_cmd_rd(crd), .i_cmd_code(code), .i_page(pg), .i_wr_data(wdata),
    .i_clear_faults(clr), .i_output_good(good), .i_vout_below_uv(below),
    .i_enable_pin(en), .i_operation_on(op), .i_bias_good(bias), .i_other_shutdown(oth),
    .i_sample_valid(sv), .i_current_sample(samp), .i_blank_done(blank),
    .i_consec_count(need), .i_avg_oc_fault(aoc), .i_avg_uc_fault(auc),
    .o_rd_data(rd_data), .o_rd_valid(rd_valid), .o_output_disable(dis),
    .o_uv_fault_flag(uvf), .o_oc_fault_flag(ocf), .o_uc_fault_flag(ucf),
    .o_oc_event(oce), .o_uc_event(uce), .o_alert_line_n(alert_n));

  // free-running 10 MHz clock
  always #50 clk = ~clk;

  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : xs

  // the action register keeps only its low byte
  function automatic word_t keep(input int k, input word_t d);
    return (k == 0) ? {8'h00, d[7:0]} : d;
  endfunction : keep

  task automatic cmp_w(input string n, input word_t e, input word_t o);
    compares++;
    if (o !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, o);
    end
  endtask : cmp_w

  task automatic cmp_b(input string n, input logic [1:0] e, input logic [1:0] o);
    compares++;
    if (o !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %b seen %b", n, e, o);
    end
  endtask : cmp_b

  task automatic end_sim();
    $display("mismatches %0d compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : end_sim

  task automatic cleared();
    cmp_b("flags clear", 2'b00, uvf | ocf | ucf);
    cmp_b("enabled", 2'b00, dis);
    cmp_b("alert idle", 2'b01, {1'b0, alert_n});
  endtask : cleared

  // arm output good, then one undervoltage cycle on page 0
  task automatic uv_fire(input logic [7:0] act);
    host.wr(1'b0, 8'h45, {8'h00, act});
    good[0] = 1'b1;
    repeat (3) @(negedge clk);
    below[0] = 1'b1;
    @(negedge clk);
    below[0] = 1'b0;
    good[0]  = 1'b0;
    cmp_b("uv flag", 2'b01, uvf);
    cmp_b("alert", 2'b00, {1'b0, alert_n});
    cmp_b("disable", {1'b0, act[7:6] == 2'b10}, dis);
  endtask : uv_fire

  // retry 111 re-enables after exactly the retry time unless a stop cause
  // (0 operation, 1 enable pin, 2 bias, 3 other shutdown) arrives meanwhile
  task automatic retry_case(input logic stop, input int how);
    uv_fire(8'hb8);
    op[0]  = !(stop && how == 0);
    en[0]  = !(stop && how == 1);
    bias   = !(stop && how == 2);
    oth[0] = stop && how == 3;
    repeat (RC - 1) @(negedge clk);
    cmp_b("retry wait", 2'b01, dis);
    @(negedge clk);
    cmp_b("retry end", {1'b0, stop}, dis);
    cmp_b("flag kept", 2'b01, uvf);
    {op[0], en[0], bias, oth[0]} = 4'he;
    host.clear();
    cleared();
  endtask : retry_case

  task automatic smp(input logic q, input word_t d, input logic b);
    @(negedge clk);
    sv[q]    = 1'b1;
    samp[q]  = d;
    blank[q] = b;
    @(negedge clk);
    sv[q]    = 1'b0;
    samp[q]  = ~d;
  endtask : smp

  // a run of samples beyond the limit, broken by an equal and a blanked one
  task automatic thr_case(input logic q, input logic uc);
    word_t hit;
    word_t lim;
    hit  = uc ? {5'h1b, 11'h544} : {5'h1b, 11'd700};
    lim  = uc ? 16'hdd80 : 16'hda80;
    host.wr(q, uc ? 8'h4b : 8'h46, lim);
    need = 4'd3;
    smp(q, hit, 1'b1);
    smp(q, hit, 1'b1);
    smp(q, lim, 1'b1);
    smp(q, hit, 1'b1);
    smp(q, hit, 1'b1);
    smp(q, hit, 1'b0);
    smp(q, hit, 1'b1);
    smp(q, hit, 1'b1);
    repeat (3) @(negedge clk);
    cmp_b("no early fault", 2'b00, uc ? ucf : ocf);
    smp(q, hit, 1'b1);
    cmp_b("current fault", 2'b01 << q, uc ? ucf : ocf);
    cmp_b("current event", 2'b01 << q, uc ? uce : oce);
    host.clear();
    cleared();
    aoc[q] = ~uc;
    auc[q] = uc;
    @(negedge clk);
    aoc = 2'b00;
    auc = 2'b00;
    cmp_b("shared flag", 2'b01 << q, uc ? ucf : ocf);
    cmp_b("shared event", 2'b01 << q, uc ? uce : oce);
    host.clear();
  endtask : thr_case

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    {good, below, sv, aoc, auc, oth} = '0;
    {en, op, blank} = 6'h3f;
    bias = 1'b1;
    need = 4'd1;
    samp = '0;
    rng = 32'd46505;
    repeat (3) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    for (int q = 0; q < 2; q++) begin
      for (int k = 0; k < 3; k++) begin
        host.rd(q[0], codes[k], v, g);
        cmp_w("reset word", rst_w[k], g);
        shw[q][k] = rst_w[k];
      end
    end
    repeat (16) begin
      rng = xs(rng);
      p = rng[0];
      s = rng[9:8] % 3;
      w = (s == 0) ? rng[31:16] : {5'h1b, rng[26:16]}; // within 32 A
      host.wr(p, codes[s], w);
      shw[p][s] = keep(s, w);
    end
    for (int q = 0; q < 2; q++) begin
      for (int k = 0; k < 3; k++) begin
        host.rd(q[0], codes[k], v, g);
        cmp_b("read valid", 2'b01, {1'b0, v});
        cmp_w("paged word", shw[q][k], g);
      end
    end
    host.rd(1'b0, 8'h47, v, g);
    cmp_b("unmapped read", 2'b00, {1'b0, v});
    below[0] = 1'b1;
    repeat (5) @(negedge clk);
    cmp_b("no uv before good", 2'b00, uvf);
    below[0] = 1'b0;
    foreach (acts[i]) begin
      uv_fire(acts[i]);
      repeat (RC + 5) @(negedge clk);
      cmp_b("held off", {1'b0, acts[i][7:6] == 2'b10}, dis);
      cmp_b("flag sticky", 2'b01, uvf);
      host.clear();
      cleared();
    end
    retry_case(1'b0, 0);
    for (int h = 0; h < 4; h++) begin
      retry_case(1'b1, h);
    end
    thr_case(1'b1, 1'b0);
    thr_case(1'b0, 1'b1);
    // a reset in mid-run must bring back every default, page 1 included
    rst_n = 1'b0;
    @(negedge clk);
    rst_n = 1'b1;
    cleared();
    for (int k = 0; k < 3; k++) begin
      host.rd(1'b1, codes[k], v, g);
      cmp_w("reset again", rst_w[k], g);
    end
    end_sim();
  end

  // watchdog well beyond the few hundred cycles the scenarios need
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    end_sim();
  end
endmodule : output_fault_response_regs_tb_top
